// File: logic/sxip_pkg.sv
// shared constants, states and helpers of the execute-in-place controller
package sxip_pkg;
  // ==========================================================
  // register map
  localparam logic [31:0] SXIP_BASE = 32'hffff4000; // block base address
  localparam logic [3:0] SXIP_OFF_CTRL = 4'h0; // module_control
  localparam logic [3:0] SXIP_OFF_RSVD = 4'h4; // reserved, reads zero
  localparam logic [3:0] SXIP_OFF_LOW = 4'h8; // spi_data_low
  localparam logic [3:0] SXIP_OFF_HIGH = 4'hc; // spi_data_high
  localparam logic [31:0] SXIP_CTRL_RST = 32'h00000000; // control reset
  localparam logic [31:0] SXIP_CTRL_WMASK = 32'h07ffffff; // writable bits
  // ==========================================================
  // control field positions
  localparam int SXIP_B_EN = 0; // module enable
  localparam int SXIP_B_PRSC = 1; // coarse_prescale_sel, 3 bits
  localparam int SXIP_B_CPOL = 4; // clock_polarity
  localparam int SXIP_B_CPHA = 5; // clock_phase
  localparam int SXIP_B_NB = 6; // transfer_byte_count, 4 bits
  localparam int SXIP_B_XEN = 10; // execute-in-place enable
  localparam int SXIP_B_AB = 11; // address_bytes_minus_one, 2 bits
  localparam int SXIP_B_CMD = 13; // read opcode, 8 bits
  localparam int SXIP_B_CSEN = 21; // select_permit
  localparam int SXIP_B_FAST = 22; // fast_clock_mode
  localparam int SXIP_B_CDIV = 23; // fine_clock_divider, 4 bits
  localparam int SXIP_B_PBUSY = 30; // serial_phy_busy
  localparam int SXIP_B_XBUSY = 31; // transparent access busy
  // ==========================================================
  // transfer shapes
  localparam logic [3:0] SXIP_REGION = 4'he; // top nibble of flash window
  localparam int SXIP_TX_W = 72; // widest shift word
  localparam int SXIP_HALF_W = 17; // half-period counter width
  localparam logic [7:0] SXIP_HDR_FIX = 8'h02; // opcode + one address byte
  // ==========================================================
  // controller states, gray along idle-read-done
  typedef enum logic [1:0] {
    SXIP_S_IDLE = 2'b00,
    SXIP_S_DIRECT = 2'b10,
    SXIP_S_XREAD = 2'b01,
    SXIP_S_XDONE = 2'b11
  } sxip_state_e;
  // ==========================================================
  // coarse prescaler code to division factor
  function automatic logic [12:0] sxip_presc(input logic [2:0] sel);
    case (sel)
      3'h0: sxip_presc = 13'h0002;
      3'h1: sxip_presc = 13'h0004;
      3'h2: sxip_presc = 13'h0008;
      3'h3: sxip_presc = 13'h0040;
      3'h4: sxip_presc = 13'h0080;
      3'h5: sxip_presc = 13'h0400;
      3'h6: sxip_presc = 13'h0800;
      default: sxip_presc = 13'h1000;
    endcase
  endfunction
  // flash byte order to core word order
  function automatic logic [31:0] sxip_swap(input logic [31:0] w);
    sxip_swap = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction
endpackage

// File: logic/sxip_phy.sv
// serial shift engine with clock generator and chip select
`timescale 1ns/1ns
module sxip_phy
  import sxip_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic abort, // synchronous kill of any transfer
  input wire logic start, // one-cycle start pulse
  input wire logic [SXIP_TX_W-1:0] tx, // msb-aligned send word
  input wire logic [7:0] nbytes, // bytes to shift
  input wire logic [SXIP_HALF_W-1:0] half, // clocks per half period
  input wire logic cpol,
  input wire logic cpha,
  input wire logic csen,
  input wire logic spi_sdi,
  output logic busy,
  output logic byte_done, // pulse per finished byte
  output logic done, // pulse at transfer end
  output logic [31:0] rx, // last 32 received bits
  output logic spi_clk,
  output logic spi_cs_n,
  output logic spi_sdo
);
  // ==========================================================
  // data-in synchroniser
  logic [2:0] sync_q; // [0] is the raw capture stage
  logic sdi_q; // filtered level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_q <= 3'h0;
      sdi_q <= 1'b0;
    end else begin
      sync_q <= {sync_q[1:0], spi_sdi};
      // a change counts once two later stages agree
      if (sync_q[1] == sync_q[2]) begin
        sdi_q <= sync_q[2];
      end
    end
  end
  // ==========================================================
  // shift engine
  logic [SXIP_TX_W-1:0] sr_q; // send shifter, zeros fill in
  logic [SXIP_HALF_W-1:0] hcnt_q; // half-period counter
  logic ph_q; // 0 first half of a bit, 1 second half
  logic lvl_q; // clock level before polarity
  logic [2:0] bit_q; // bit in byte
  logic [7:0] left_q; // bytes still to go
  logic lead_q; // no leading edge yet in this transfer
  logic tick; // half period expires
  assign tick = busy & (hcnt_q == half - 17'h00001);
  // one process owns the whole engine; abort clears only busy and the clock level, other state holds
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      sr_q <= '0;
      hcnt_q <= '0;
      ph_q <= 1'b0;
      lvl_q <= 1'b0;
      bit_q <= 3'h0;
      left_q <= 8'h00;
      lead_q <= 1'b0;
      rx <= 32'h0;
      byte_done <= 1'b0;
      done <= 1'b0;
    end else begin
      byte_done <= 1'b0;
      done <= 1'b0;
      if (abort) begin
        busy <= 1'b0;
        lvl_q <= 1'b0;
      end else if (start && !busy) begin
        busy <= 1'b1;
        sr_q <= tx;
        hcnt_q <= '0;
        ph_q <= 1'b0;
        lvl_q <= 1'b0;
        bit_q <= 3'h0;
        left_q <= nbytes;
        lead_q <= 1'b1;
      end else if (tick) begin
        hcnt_q <= '0;
        ph_q <= ~ph_q;
        lvl_q <= ~ph_q;
        // sample on leading edge in phase 0, trailing in phase 1
        if (ph_q == cpha) begin
          rx <= {rx[30:0], sdi_q};
        end
        // shift on the edge opposite to sampling, so the line never
        // moves on the edge the flash samples; phase 1 keeps the
        // first bit over the first leading edge
        if (cpha ? (!ph_q && !lead_q) : ph_q) begin
          sr_q <= {sr_q[SXIP_TX_W-2:0], 1'b0};
        end
        if (!ph_q) begin
          lead_q <= 1'b0;
        end
        if (ph_q) begin
          bit_q <= bit_q + 3'h1;
          if (bit_q == 3'h7) begin
            byte_done <= 1'b1;
            left_q <= left_q - 8'h01;
            if (left_q == 8'h01) begin
              busy <= 1'b0;
              done <= 1'b1;
            end
          end
        end
      end else if (busy) begin
        hcnt_q <= hcnt_q + 17'h00001;
      end
    end
  end
  // ==========================================================
  // pins: select follows the engine and the permit bit
  assign spi_cs_n = ~(busy & csen);
  assign spi_clk = lvl_q ^ cpol;
  assign spi_sdo = sr_q[SXIP_TX_W-1];
  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_CS_RELEASE: assert property ($fell(busy) |-> spi_cs_n)
    else $error("select held after transfer end");
  AST_IDLE_POL: assert property (!busy && !$past(busy) |-> spi_clk == cpol)
    else $error("idle clock level differs from polarity");
  AST_EDGE_TICK: assert property ($changed(lvl_q) && !$past(abort)
    |-> $past(tick))
    else $error("clock edge off the half-period grid");
endmodule

// File: logic/sxip_cache.sv
// direct-mapped read-only block cache for flash words
`timescale 1ns/1ns
module sxip_cache
  import sxip_pkg::*;
#(
  parameter int NUM_BLOCKS = 4, // power of two, at least 2
  parameter int BLOCK_SIZE = 16 // bytes, power of two, 8 to 128
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear, // invalidate every block
  input wire logic [27:0] lk_addr, // lookup byte address
  output logic lk_hit,
  output logic [31:0] lk_data,
  input wire logic wr_en, // fill one word
  input wire logic wr_last, // last word of the block
  input wire logic [27:0] wr_addr,
  input wire logic [31:0] wr_data
);
  localparam int OFF_W = $clog2(BLOCK_SIZE);
  localparam int IDX_W = $clog2(NUM_BLOCKS);
  localparam int TAG_W = 28 - OFF_W - IDX_W;
  localparam int WORDS = NUM_BLOCKS * BLOCK_SIZE / 4;
  // ==========================================================
  // storage
  logic [31:0] data_q [WORDS]; // word array, no reset needed
  logic [TAG_W-1:0] tag_q [NUM_BLOCKS]; // block tags
  logic [NUM_BLOCKS-1:0] val_q; // block valid flags
  logic [IDX_W-1:0] lk_idx; // lookup block
  logic [IDX_W-1:0] wr_idx; // fill block
  assign lk_idx = lk_addr[OFF_W +: IDX_W];
  assign wr_idx = wr_addr[OFF_W +: IDX_W];
  assign lk_hit = val_q[lk_idx] & (tag_q[lk_idx] == lk_addr[27 -: TAG_W]);
  assign lk_data = data_q[{lk_idx, lk_addr[OFF_W-1:2]}];
  // ==========================================================
  // word fill; a block only turns valid once all its words are in
  always_ff @(posedge clk) begin
    if (wr_en) begin
      data_q[{wr_idx, wr_addr[OFF_W-1:2]}] <= wr_data;
    end
  end
  // ==========================================================
  // tags and valid flags; clear wins so a fence is never missed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      val_q <= '0;
      for (int i = 0; i < NUM_BLOCKS; i++) begin
        tag_q[i] <= '0;
      end
    end else if (clear) begin
      val_q <= '0;
    end else if (wr_en && wr_last) begin
      val_q[wr_idx] <= 1'b1;
      tag_q[wr_idx] <= wr_addr[27 -: TAG_W];
    end
  end
  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_CLEAR_MISS: assert property (clear |=> !lk_hit)
    else $error("hit right after invalidation");
endmodule

// File: logic/sxip_top.sv
// execute-in-place controller: registers, flash window and sequencing
`timescale 1ns/1ns
module sxip_top
  import sxip_pkg::*;
#(
  parameter bit CACHE_EN = 1'b1, // build the block cache
  parameter int NUM_BLOCKS = 4, // cache blocks, power of two
  parameter int BLOCK_SIZE = 16 // bytes per block, power of two
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic io_stb, // register access strobe
  input wire logic io_we, // register write
  input wire logic [31:0] io_addr,
  input wire logic [31:0] io_wdata,
  output logic [31:0] io_rdata,
  output logic io_ack,
  input wire logic xip_req, // flash window request strobe
  input wire logic xip_we, // window write attempt
  input wire logic [31:0] xip_addr,
  output logic [31:0] xip_rdata,
  output logic xip_ack,
  output logic xip_err,
  input wire logic fence, // core fence pulse
  output logic spi_cs_n,
  output logic spi_clk,
  output logic spi_sdo,
  input wire logic spi_sdi
);
  localparam int OFF_W = $clog2(BLOCK_SIZE);
  localparam logic [7:0] BLK_BYTES = 8'(BLOCK_SIZE);
  // ==========================================================
  // control fields
  logic [31:0] ctrl_q; // software-written control
  logic en; // module enable
  logic xen; // flash window enable
  logic csen; // select_permit
  logic [1:0] ab; // address_bytes_minus_one
  logic [7:0] cmd; // read opcode
  logic [3:0] nb; // transfer_byte_count
  assign en = ctrl_q[SXIP_B_EN];
  assign xen = ctrl_q[SXIP_B_XEN];
  assign csen = ctrl_q[SXIP_B_CSEN];
  assign ab = ctrl_q[SXIP_B_AB +: 2];
  assign cmd = ctrl_q[SXIP_B_CMD +: 8];
  assign nb = ctrl_q[SXIP_B_NB +: 4];
  // ==========================================================
  // clock rate: half period in main clocks
  logic [12:0] factor; // coarse factor after fast override
  logic [17:0] half_full; // factor times fine step
  logic [SXIP_HALF_W-1:0] half; // clocks per half period
  always_comb begin
    factor = sxip_presc(ctrl_q[SXIP_B_PRSC +: 3]);
    if (ctrl_q[SXIP_B_FAST]) begin
      factor = 13'h0001;
    end
  end
  assign half_full = factor * {1'b0, ctrl_q[SXIP_B_CDIV +: 4]} + 18'(factor);
  assign half = half_full[SXIP_HALF_W-1:0];
  // ==========================================================
  // bus decode
  logic sel; // access inside the block's span
  logic [3:0] off; // register offset
  logic wr_high; // write to spi_data_high
  assign sel = io_stb & (io_addr[31:4] == SXIP_BASE[31:4]);
  assign off = io_addr[3:0];
  assign wr_high = sel & io_we & (off == SXIP_OFF_HIGH);
  // ==========================================================
  // sequencer signals
  sxip_state_e st_q; // controller state
  logic phy_busy;
  logic phy_done;
  logic phy_byte;
  logic [31:0] phy_rx;
  logic phy_start;
  logic [SXIP_TX_W-1:0] phy_tx;
  logic [7:0] phy_nb;
  logic [31:0] spi_data_low_q; // send low half / received word
  logic go_direct; // accepted direct transfer
  logic xip_take; // window request in idle
  logic xip_bad; // window request to refuse
  logic hit; // cache hit on the idle lookup
  logic [31:0] hit_data;
  logic [27:0] addr_q; // captured window address
  logic [27:0] lk_addr; // cache lookup address
  logic [31:0] xa; // aligned window address
  logic [7:0] hdr; // opcode plus address bytes
  logic [7:0] bc_q; // finished bytes of this read
  logic [7:0] di; // data byte index
  logic fill_wr;
  logic fill_last;
  logic cache_clr;
  assign go_direct = wr_high & en & ~xen & (st_q == SXIP_S_IDLE);
  assign xip_take = xip_req & (st_q == SXIP_S_IDLE);
  assign xip_bad = xip_we | ~en | ~xen
    | (xip_addr[31:28] != SXIP_REGION);
  assign hdr = {6'h00, ab} + SXIP_HDR_FIX;
  assign di = bc_q - hdr;
  assign lk_addr = (st_q == SXIP_S_IDLE) ? xip_addr[27:0] : addr_q;
  assign cache_clr = ~en | ~xen | fence;
  // ==========================================================
  // send word: top nibble is zero so four-byte addresses stay in range
  always_comb begin
    xa = {4'h0, xip_addr[27:0]};
    if (CACHE_EN) begin
      xa = xa & ~32'(BLOCK_SIZE - 1);
    end else begin
      xa = xa & ~32'h00000003;
    end
    if (go_direct) begin
      phy_tx = {io_wdata, spi_data_low_q, 8'h00};
      phy_nb = {4'h0, nb};
    end else begin
      phy_tx = {cmd, xa << {~ab, 3'b000}, 32'h0};
      phy_nb = CACHE_EN ? hdr + BLK_BYTES : {4'h0, nb};
    end
  end
  assign phy_start = go_direct | (xip_take & ~xip_bad & ~hit);
  // ==========================================================
  // cache fill: every fourth data byte completes one word
  assign fill_wr = (st_q == SXIP_S_XREAD) & phy_byte & (bc_q >= hdr)
    & (di[1:0] == 2'b11);
  assign fill_last = di == BLK_BYTES - 8'h01;
  generate
    if (CACHE_EN) begin : g_cache
      logic lk_hit_w;
      sxip_cache #(
        .NUM_BLOCKS(NUM_BLOCKS),
        .BLOCK_SIZE(BLOCK_SIZE)
      ) u_cache (
        .clk(clk),
        .rst_n(rst_n),
        .clear(cache_clr),
        .lk_addr(lk_addr),
        .lk_hit(lk_hit_w),
        .lk_data(hit_data),
        .wr_en(fill_wr),
        .wr_last(fill_last),
        .wr_addr({addr_q[27:OFF_W], di[OFF_W-1:0]}),
        .wr_data(sxip_swap(phy_rx))
      );
      assign hit = lk_hit_w & (st_q == SXIP_S_IDLE);
    end else begin : g_nocache
      assign hit = 1'b0;
      assign hit_data = 32'h0;
    end
  endgenerate
  // ==========================================================
  // control register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= SXIP_CTRL_RST;
    end else if (sel && io_we && off == SXIP_OFF_CTRL) begin
      ctrl_q <= io_wdata & SXIP_CTRL_WMASK;
    end
  end
  // ==========================================================
  // direct data; received word overrides a racing software write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      spi_data_low_q <= 32'h0;
    end else if (!en) begin
      spi_data_low_q <= 32'h0;
    end else if (st_q == SXIP_S_DIRECT && phy_done) begin
      spi_data_low_q <= phy_rx;
    end else if (sel && io_we && off == SXIP_OFF_LOW) begin
      spi_data_low_q <= io_wdata;
    end
  end
  // ==========================================================
  // register read and acknowledge; high half is write-only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      io_ack <= 1'b0;
      io_rdata <= 32'h0;
    end else begin
      io_ack <= sel;
      io_rdata <= 32'h0;
      if (sel && !io_we) begin
        unique case (off)
          SXIP_OFF_CTRL: begin
            io_rdata <= ctrl_q;
            io_rdata[SXIP_B_PBUSY] <= phy_busy;
            io_rdata[SXIP_B_XBUSY] <= st_q[0];
          end
          SXIP_OFF_LOW: io_rdata <= spi_data_low_q;
          default: io_rdata <= 32'h0;
        endcase
      end
    end
  end
  // ==========================================================
  // sequencer and window answers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= SXIP_S_IDLE;
      addr_q <= 28'h0;
      xip_ack <= 1'b0;
      xip_err <= 1'b0;
      xip_rdata <= 32'h0;
    end else begin
      xip_ack <= 1'b0;
      xip_err <= 1'b0;
      unique case (st_q)
        SXIP_S_IDLE: begin
          if (go_direct) begin
            st_q <= SXIP_S_DIRECT;
          end else if (xip_take) begin
            addr_q <= xip_addr[27:0];
            if (xip_bad) begin
              xip_err <= 1'b1;
            end else if (hit) begin
              xip_rdata <= hit_data;
              xip_ack <= 1'b1;
            end else begin
              st_q <= SXIP_S_XREAD;
            end
          end
        end
        SXIP_S_DIRECT: begin
          if (!en || phy_done) begin
            st_q <= SXIP_S_IDLE;
          end
        end
        SXIP_S_XREAD: begin
          if (!en || !xen) begin
            xip_err <= 1'b1;
            st_q <= SXIP_S_IDLE;
          end else if (phy_done) begin
            if (CACHE_EN) begin
              st_q <= SXIP_S_XDONE;
            end else begin
              xip_rdata <= sxip_swap(phy_rx);
              xip_ack <= 1'b1;
              st_q <= SXIP_S_IDLE;
            end
          end
        end
        SXIP_S_XDONE: begin
          xip_rdata <= hit_data;
          xip_ack <= 1'b1;
          st_q <= SXIP_S_IDLE;
        end
      endcase
    end
  end
  // ==========================================================
  // byte counter of the running window read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bc_q <= 8'h00;
    end else if (st_q != SXIP_S_XREAD) begin
      bc_q <= 8'h00;
    end else if (phy_byte) begin
      bc_q <= bc_q + 8'h01;
    end
  end
  // ==========================================================
  // serial engine
  sxip_phy u_phy (
    .clk(clk),
    .rst_n(rst_n),
    .abort(~en | (~xen & st_q[0])),
    .start(phy_start),
    .tx(phy_tx),
    .nbytes(phy_nb),
    .half(half),
    .cpol(ctrl_q[SXIP_B_CPOL]),
    .cpha(ctrl_q[SXIP_B_CPHA]),
    .csen(csen),
    .spi_sdi(spi_sdi),
    .busy(phy_busy),
    .byte_done(phy_byte),
    .done(phy_done),
    .rx(phy_rx),
    .spi_clk(spi_clk),
    .spi_cs_n(spi_cs_n),
    .spi_sdo(spi_sdo)
  );
  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_direct_go;
    wr_high && en && !xen && st_q == SXIP_S_IDLE;
  endsequence
  sequence s_running;
    phy_busy && st_q == SXIP_S_DIRECT;
  endsequence
  AST_DIRECT_START: assert property (s_direct_go |=> s_running)
    else $error("direct transfer did not start");
  AST_NO_DIRECT_XIP: assert property (wr_high && xen
    && st_q == SXIP_S_IDLE && !phy_busy && !xip_req |=> !phy_busy)
    else $error("data write started a transfer in window mode");
  AST_WRITE_ERR: assert property (xip_take && xip_we |=> xip_err)
    else $error("window write not refused");
  AST_REGION: assert property (xip_take
    && xip_addr[31:28] != SXIP_REGION |=> xip_err && !xip_ack)
    else $error("access outside window not refused");
  AST_OFF_ERR: assert property (xip_take && (!en || !xen) |=> xip_err)
    else $error("window access answered while off");
  AST_CS_PERMIT: assert property (!csen |-> spi_cs_n)
    else $error("select asserted without permit");
  AST_ABORT: assert property (!en |=> !phy_busy && st_q != SXIP_S_DIRECT)
    else $error("transfer survived disable");
  AST_ONE_ACK: assert property (xip_ack |=> !xip_ack)
    else $error("window read acknowledged twice");
  AST_FAST_HALF: assert property (ctrl_q[SXIP_B_FAST]
    |-> half == 17'(ctrl_q[SXIP_B_CDIV +: 4]) + 17'h00001)
    else $error("fast mode half period wrong");
endmodule

// File: bench/sxip_flash_model.sv
// behavioural serial flash: read opcode, three address bytes, data burst
`timescale 1ns/1ns
module sxip_flash_model (
  input wire logic clk,
  input wire logic cpol, // idle clock level of the mode in use
  input wire logic cpha, // sample on the trailing edge when set
  input wire logic spi_cs_n,
  input wire logic spi_clk,
  input wire logic spi_sdo,
  output logic spi_sdi
);
  int cnt_q; // bits seen in this frame
  logic [23:0] sh_q; // incoming bits
  logic [23:0] addr_q; // latched read address
  logic [7:0] cur; // byte now being returned
  logic mclk; // rises on every sampling edge, whatever the mode
  assign mclk = spi_clk ^ cpol ^ cpha;
  initial spi_sdi = 1'b0;
  // ==========================================================
  // capture msb first on the sampling edge of any of the four modes
  always @(posedge mclk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      cnt_q <= 0;
    end else begin
      sh_q <= {sh_q[22:0], spi_sdo};
      if (cnt_q == 31) begin
        addr_q <= {sh_q[22:0], spi_sdo};
      end
      cnt_q <= cnt_q + 1;
    end
  end
  // each byte holds its own low address bits; a burst walks upward
  assign cur = 8'(addr_q + 24'((cnt_q - 32) / 8));
  always @(negedge mclk) begin
    if (!spi_cs_n && cnt_q >= 32) begin
      spi_sdi <= cur[7 - cnt_q % 8];
    end
  end
  // released line toggles so a stale bit never passes for data
  always @(posedge clk) begin
    if (spi_cs_n) begin
      spi_sdi <= ~spi_sdi;
    end
  end
endmodule

// File: bench/spi_flash_execute_in_place_tb.sv
// bench for the execute-in-place controller
`timescale 1ns/1ns
module spi_flash_execute_in_place_tb import sxip_pkg::*;;
  typedef struct {bit we; logic [3:0] of; logic [31:0] wd, ex;} sxip_row_s;
  localparam logic [31:0] CB = 32'h02607201; // direct, 8 bytes, half 5
  localparam logic [31:0] CX = 32'h02607601; // same with window on
  localparam logic [31:0] CN = 32'h02407201; // select not permitted
  localparam logic [31:0] CM = 32'h02607231; // direct in clock mode 3
  logic clk, rst_n, io_stb, io_we, io_ack, xip_req, xip_we, xip_ack;
  logic xip_err, fence, spi_cs_n, spi_clk, spi_sdo, spi_sdi;
  logic [1:0] md; // clock mode the flash model follows
  logic [31:0] io_addr, io_wdata, io_rdata, xip_addr, xip_rdata, r;
  int mismatches, checks_done, n;
  // reset value, writable mask, reserved place, clear on disable
  sxip_row_s rows[11] = '{'{0, 4'h0, '0, '0}, '{1, 4'h0, '1, '0},
    '{0, 4'h0, '0, 32'h07ffffff}, '{1, 4'h4, 32'h12345678, '0},
    '{0, 4'h4, '0, '0}, '{0, 4'hc, '0, '0}, '{1, 4'h0, CB, '0},
    '{1, 4'h8, 32'ha5a5a5a5, '0}, '{0, 4'h8, '0, 32'ha5a5a5a5},
    '{1, 4'h0, '0, '0}, '{0, 4'h8, '0, '0}};
  // window errors: disabled, window off, write, outside region
  logic [31:0] ec[4] = '{'0, CB, CX, CX};
  logic [31:0] ea[4] = '{32'he0000000, 32'he0000000, 32'he0000000,
    32'hf0000000};
  bit ew[4] = '{0, 0, 1, 0};
  sxip_top dut (.clk(clk), .rst_n(rst_n), .io_stb(io_stb), .io_we(io_we),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .io_ack(io_ack), .xip_req(xip_req), .xip_we(xip_we),
    .xip_addr(xip_addr), .xip_rdata(xip_rdata), .xip_ack(xip_ack),
    .xip_err(xip_err), .fence(fence), .spi_cs_n(spi_cs_n),
    .spi_clk(spi_clk), .spi_sdo(spi_sdo), .spi_sdi(spi_sdi));
  sxip_flash_model flash (.clk(clk), .cpol(md[1]), .cpha(md[0]),
    .spi_cs_n(spi_cs_n),
    .spi_clk(spi_clk), .spi_sdo(spi_sdo), .spi_sdi(spi_sdi));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input bit ok);
    checks_done++;
    if (!ok) begin
      mismatches++;
      $display("[FAIL] %0t mismatch", $time);
    end
  endtask
  // one register access; ack is looked at in its only cycle
  task automatic io(bit we, logic [3:0] of, logic [31:0] wd);
    @(negedge clk);
    {io_stb, io_we, io_addr, io_wdata} = {1'b1, we, SXIP_BASE | of, wd};
    @(negedge clk);
    io_stb = 1'b0;
    chk(io_ack === 1'b1);
    r = io_rdata;
  endtask
  // window request, counts cycles to the answer under a bound
  task automatic xr(bit we, logic [31:0] a);
    @(negedge clk);
    {xip_req, xip_we, xip_addr} = {1'b1, we, a};
    @(negedge clk);
    xip_req = 1'b0;
    for (n = 0; xip_ack !== 1'b1 && xip_err !== 1'b1 && n < 4000; n++)
      @(negedge clk);
  endtask
  // polls the busy flag afresh; running out of polls is a mismatch
  task automatic wait_phy();
    io(0, 0, 0);
    for (int i = 0; i < 1000 && r[SXIP_B_PBUSY] !== 1'b0; i++) io(0, 0, 0);
    chk(r[SXIP_B_PBUSY] === 1'b0);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    {rst_n, io_stb, io_we, io_addr, io_wdata} = '0;
    {xip_req, xip_we, xip_addr, fence, md} = '0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      io(rows[i].we, rows[i].of, rows[i].wd);
      if (!rows[i].we) chk(r === rows[i].ex);
    end
    // direct transfer: opcode and address high, reply lands in low
    io(1, 0, CB);
    io(1, 8, '0);
    io(1, 12, 32'h03000010);
    io(0, 0, 0);
    chk(r[SXIP_B_PBUSY] === 1'b1);
    chk(spi_cs_n === 1'b0);
    wait_phy();
    chk(spi_cs_n === 1'b1);
    io(0, 8, 0);
    chk(r === 32'h10111213);
    // mode 3: clock idles high, data moves on leading edges
    md = 2'h3;
    io(1, 0, CM);
    chk(spi_clk === 1'b1);
    io(1, 12, 32'h03000020);
    wait_phy();
    io(0, 8, 0);
    chk(r === 32'h20212223);
    md = 2'h0;
    io(1, 0, CN);
    io(1, 12, 32'h03000010);
    chk(spi_cs_n === 1'b1);
    wait_phy();
    io(1, 0, CX);
    io(1, 12, 32'h03000010);
    io(0, 0, 0);
    chk(r[SXIP_B_PBUSY] === 1'b0 && spi_cs_n === 1'b1);
    // miss fills the block, neighbour hits, fence forces a refill
    xr(0, 32'he0000010);
    chk(xip_ack === 1'b1 && xip_rdata === 32'h13121110);
    xr(0, 32'he0000014);
    chk(xip_ack === 1'b1 && n == 0 && xip_rdata === 32'h17161514);
    @(negedge clk);
    fence = 1'b1;
    @(negedge clk);
    fence = 1'b0;
    xr(0, 32'he0000014);
    chk(xip_ack === 1'b1 && n > 20 && xip_rdata === 32'h17161514);
    for (int i = 0; i < 4; i++) begin
      io(1, 0, ec[i]);
      xr(ew[i], ea[i]);
      chk(xip_err === 1'b1 && n == 0);
    end
    // disabling mid transfer drops the select at once
    io(1, 0, CB);
    io(1, 12, 32'h03000010);
    io(1, 0, 0);
    io(0, 0, 0);
    chk(r === 32'h0 && spi_cs_n === 1'b1);
    print_verdict();
  end
  // watchdog well past the expected few thousand cycles
  initial begin
    #2000000;
    mismatches++;
    print_verdict();
  end
endmodule
